// ==== inc/cat_pkg.sv ====
// package for the counter array timebase control block
package cat_pkg;
  localparam logic [7:0] CAT_CTRL_ADDR = 8'hD8;
  localparam logic [7:0] CAT_MODE_ADDR = 8'hD9;
  localparam logic [7:0] CAT_CTRL_RST  = 8'h00;
  localparam logic [7:0] CAT_MODE_RST  = 8'h00;
  // control register fields
  localparam int CAT_CF_BIT   = 7;
  localparam int CAT_CR_BIT   = 6;
  // mode register fields
  localparam int CAT_IDL_BIT  = 7;
  localparam int CAT_SEL_LSB  = 1;
  localparam int CAT_ECF_BIT  = 0;
  localparam int CAT_NMOD     = 6;
  localparam logic [15:0] CAT_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CAT_CNT_RST = 16'h0000;
  // divider ratios in system clock cycles, except CAT_OSC_DIV in oscillator rising edges
  localparam int CAT_DIV12    = 12;
  localparam int CAT_DIV4     = 4;
  localparam int CAT_OSC_DIV  = 8;

  typedef enum logic [2:0] {
    CAT_SEL_DIV12 = 3'h0,
    CAT_SEL_T0    = 3'h2,
    CAT_SEL_DIV4  = 3'h1,
    CAT_SEL_ECI   = 3'h3,
    CAT_SEL_SYS   = 3'h4,
    CAT_SEL_EXT   = 3'h5,
    CAT_SEL_LF    = 3'h6,
    CAT_SEL_NONE  = 3'h7
  } cat_sel_e;

  // special function register write/read port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cat_sfr_s;

  // per-module event inputs from the capture/compare modules
  typedef struct packed {
    logic [5:0] capcmp;
    logic [5:0] pwm_edge;
    logic [5:0] match_en;
    logic [5:0] pwm_mode;
    logic [5:0] int_en;
  } cat_mod_s;

  typedef enum logic [2:0] {
    CAT_ST_STOP = 3'b001,
    CAT_ST_RUN  = 3'b010,
    CAT_ST_SUSP = 3'b100
  } cat_state_e;
endpackage

// ==== core/cat_tick_gen.sv ====
// timebase tick generator: dividers, synchronisers and source select
`timescale 1ns/10ps
`default_nettype none
module cat_tick_gen
  import cat_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // source selection
  input  wire logic [2:0] sel,
  input  wire logic       t0_ovf,
  // asynchronous sources
  input  wire logic       eci_pin,
  input  wire logic       ext_osc,
  input  wire logic       lf_osc,
  // selected tick
  output logic            tick
);
  logic [3:0] div12_ff;
  logic [1:0] div4_ff;
  logic [2:0] ext_cnt_ff;
  logic [2:0] lf_cnt_ff;
  logic [2:0] eci_sync_ff;
  logic [2:0] ext_sync_ff;
  logic [2:0] lf_sync_ff;
  logic       tick_div12;
  logic       tick_div4;
  logic       tick_eci;
  logic       tick_ext;
  logic       tick_lf;

  function automatic logic rise(input logic [2:0] s);
    rise = s[1] & ~s[2];
  endfunction

  assign tick_div12 = (div12_ff == 4'(CAT_DIV12 - 1));
  assign tick_div4  = (div4_ff == 2'(CAT_DIV4 - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div12_ff <= 4'h0;
      div4_ff  <= 2'h0;
    end else begin
      div12_ff <= tick_div12 ? 4'h0 : div12_ff + 4'h1;
      div4_ff  <= div4_ff + 2'h1;
    end
  end

  // bit 0 is the metastable stage; bits 1 and 2 feed the edge detect
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eci_sync_ff <= 3'h7;
      ext_sync_ff <= 3'h0;
      lf_sync_ff  <= 3'h0;
    end else begin
      eci_sync_ff <= {eci_sync_ff[1:0], eci_pin};
      ext_sync_ff <= {ext_sync_ff[1:0], ext_osc};
      lf_sync_ff  <= {lf_sync_ff[1:0], lf_osc};
    end
  end

  // falling edge of the external count input
  assign tick_eci = eci_sync_ff[2] & ~eci_sync_ff[1];

  // oscillator edges counted after synchronising, so divide by eight
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_cnt_ff <= 3'h0;
      lf_cnt_ff  <= 3'h0;
    end else begin
      if (rise(ext_sync_ff)) begin
        ext_cnt_ff <= ext_cnt_ff + 3'h1;
      end
      if (rise(lf_sync_ff)) begin
        lf_cnt_ff <= lf_cnt_ff + 3'h1;
      end
    end
  end

  assign tick_ext = rise(ext_sync_ff) && (ext_cnt_ff == 3'(CAT_OSC_DIV - 1));
  assign tick_lf  = rise(lf_sync_ff) && (lf_cnt_ff == 3'(CAT_OSC_DIV - 1));

  always_comb begin
    case (cat_sel_e'(sel))
      CAT_SEL_DIV12: tick = tick_div12;
      CAT_SEL_DIV4:  tick = tick_div4;
      CAT_SEL_T0:    tick = t0_ovf;
      CAT_SEL_ECI:   tick = tick_eci;
      CAT_SEL_SYS:   tick = 1'b1;
      CAT_SEL_EXT:   tick = tick_ext;
      CAT_SEL_LF:    tick = tick_lf;
      default:       tick = 1'b0;
    endcase
  end

  AST_DIV12_SPACING: assert property (@(posedge clk) disable iff (!rst_b)
    tick_div12 |=> !tick_div12 [*8])
    else $error("divide-by-twelve tick too close");
  AST_ECI_FALL: assert property (@(posedge clk) disable iff (!rst_b)
    tick_eci |-> $past(eci_sync_ff[1]) && !eci_sync_ff[1])
    else $error("external count tick without falling edge");
endmodule
`default_nettype wire

// ==== core/cat_timebase.sv ====
// counter array timebase control: counter, run/idle, flags, registers
`timescale 1ns/10ps
`default_nettype none
module cat_timebase
  import cat_pkg::*;
#(
  parameter int NMOD = CAT_NMOD
)(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // special function register bus
  input  wire cat_sfr_s    SFR,
  output logic [7:0]       SFR_RDATA,
  output logic             SFR_HIT,
  // processor state and timer 0
  input  wire logic        CPU_IDLE,
  input  wire logic        T0_OVF,
  // asynchronous clock sources
  input  wire logic        ECI_PIN,
  input  wire logic        EXT_OSC,
  input  wire logic        LF_OSC,
  // capture/compare module events
  input  wire cat_mod_s    MOD,
  // counter, tick and interrupt
  output logic [15:0]      COUNT,
  output logic             COUNT_TICK,
  output logic             IRQ
);
  logic [15:0]     count_ff;
  logic            ovf_flag_ff;
  logic            run_ff;
  logic [NMOD-1:0] mod_flag_ff;
  logic            idle_susp_ff;
  logic [2:0]      sel_ff;
  logic            ovf_ie_ff;
  logic [7:0]      rdata_ff;
  logic            tick_src;
  logic            advance;
  logic            wrap;
  logic            ctrl_wr;
  logic            mode_wr;
  logic [NMOD-1:0] mod_set;
  logic [NMOD-1:0] nxt_mod_flag;
  logic            nxt_ovf_flag;
  logic            suspended;
  cat_state_e      state;

  cat_tick_gen u_tick (
    .clk     (CLK),
    .rst_b   (RST_B),
    .sel     (sel_ff),
    .t0_ovf  (T0_OVF),
    .eci_pin (ECI_PIN),
    .ext_osc (EXT_OSC),
    .lf_osc  (LF_OSC),
    .tick    (tick_src)
  );

  assign ctrl_wr   = SFR.wr && (SFR.addr == CAT_CTRL_ADDR);
  assign mode_wr   = SFR.wr && (SFR.addr == CAT_MODE_ADDR);
  assign suspended = idle_susp_ff && CPU_IDLE;

  // state view of the counter, used for advance gating
  always_comb begin
    if (!run_ff) begin
      state = CAT_ST_STOP;
    end else if (suspended) begin
      state = CAT_ST_SUSP;
    end else begin
      state = CAT_ST_RUN;
    end
  end

  always_comb begin
    case (state)
      CAT_ST_RUN: advance = tick_src;
      default:    advance = 1'b0;
    endcase
  end

  assign wrap = advance && (count_ff == CAT_CNT_MAX);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      count_ff <= CAT_CNT_RST;
    end else if (advance) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // module flags: capture/compare events plus PWM edges when matched
  // suspended idle also freezes the modules, so their events are dropped
  assign mod_set = suspended ? '0 :
                   (MOD.capcmp[NMOD-1:0] |
                    (MOD.pwm_edge[NMOD-1:0] & MOD.match_en[NMOD-1:0] &
                     MOD.pwm_mode[NMOD-1:0]));

  // write first, then hardware set on top so a colliding event survives
  always_comb begin
    nxt_ovf_flag = ovf_flag_ff;
    nxt_mod_flag = mod_flag_ff;
    if (ctrl_wr) begin
      nxt_ovf_flag = SFR.wdata[CAT_CF_BIT];
      nxt_mod_flag = SFR.wdata[NMOD-1:0];
    end
    nxt_ovf_flag = nxt_ovf_flag | wrap;
    nxt_mod_flag = nxt_mod_flag | mod_set;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ovf_flag_ff <= CAT_CTRL_RST[CAT_CF_BIT];
      mod_flag_ff <= '0;
    end else begin
      ovf_flag_ff <= nxt_ovf_flag;
      mod_flag_ff <= nxt_mod_flag;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      run_ff <= CAT_CTRL_RST[CAT_CR_BIT];
    end else if (ctrl_wr) begin
      run_ff <= SFR.wdata[CAT_CR_BIT];
    end
  end

  // reserved mode bits 6:4 are not stored and read as zero
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      idle_susp_ff <= CAT_MODE_RST[CAT_IDL_BIT];
      sel_ff       <= CAT_MODE_RST[CAT_SEL_LSB +: 3];
      ovf_ie_ff    <= CAT_MODE_RST[CAT_ECF_BIT];
    end else if (mode_wr) begin
      idle_susp_ff <= SFR.wdata[CAT_IDL_BIT];
      sel_ff       <= SFR.wdata[CAT_SEL_LSB +: 3];
      ovf_ie_ff    <= SFR.wdata[CAT_ECF_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rdata_ff <= 8'h00;
    end else if (SFR.rd) begin
      case (SFR.addr)
        // the six module flags fill the low bits of the byte
        CAT_CTRL_ADDR: rdata_ff <= {ovf_flag_ff, run_ff,
                                    6'(mod_flag_ff)};
        CAT_MODE_ADDR: rdata_ff <= {idle_susp_ff, 3'h0, sel_ff, ovf_ie_ff};
        default:       rdata_ff <= 8'h00;
      endcase
    end
  end

  assign SFR_HIT = (SFR.addr == CAT_CTRL_ADDR) ||
                   (SFR.addr == CAT_MODE_ADDR);
  assign SFR_RDATA  = rdata_ff;
  assign COUNT      = count_ff;
  assign COUNT_TICK = advance;

  // one shared request: overflow gated by its enable, modules by theirs
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (ovf_flag_ff & ovf_ie_ff) |
             (|(mod_flag_ff & MOD.int_en[NMOD-1:0]));
    end
  end

  AST_WRAP_SETS_FLAG: assert property (@(posedge CLK) disable iff (!RST_B)
    wrap |=> ovf_flag_ff && count_ff == CAT_CNT_RST)
    else $error("wrap did not set overflow flag");
  AST_OVF_IRQ: assert property (@(posedge CLK) disable iff (!RST_B)
    ovf_flag_ff && ovf_ie_ff |=> IRQ)
    else $error("enabled overflow flag gave no request");
  AST_OVF_MASK: assert property (@(posedge CLK) disable iff (!RST_B)
    !ovf_ie_ff && !(|(mod_flag_ff & MOD.int_en[NMOD-1:0])) |=> !IRQ)
    else $error("masked overflow still requested");
  AST_STOP_HOLDS: assert property (@(posedge CLK) disable iff (!RST_B)
    !run_ff |=> $stable(count_ff))
    else $error("counter moved while stopped");
  AST_MOD_SET: assert property (@(posedge CLK) disable iff (!RST_B)
    mod_set[0] |=> mod_flag_ff[0])
    else $error("module event lost");
  AST_MOD_IRQ: assert property (@(posedge CLK) disable iff (!RST_B)
    |(mod_flag_ff & MOD.int_en[NMOD-1:0]) |=> IRQ)
    else $error("enabled module flag gave no request");
  AST_NO_HW_CLEAR: assert property (@(posedge CLK) disable iff (!RST_B)
    ovf_flag_ff && !ctrl_wr |=> ovf_flag_ff)
    else $error("overflow flag cleared without a write");
  AST_IDLE_SUSP: assert property (@(posedge CLK) disable iff (!RST_B)
    idle_susp_ff && CPU_IDLE |=> count_ff == $past(count_ff))
    else $error("counter moved during suspended idle");
  AST_STEP_ONE: assert property (@(posedge CLK) disable iff (!RST_B)
    advance |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("counter did not step by one");
  AST_SET_WINS: assert property (@(posedge CLK) disable iff (!RST_B)
    ctrl_wr && !SFR.wdata[CAT_CF_BIT] && wrap |=> ovf_flag_ff)
    else $error("clear beat a simultaneous overflow");

  COV_WRAP: cover property (@(posedge CLK) disable iff (!RST_B) wrap);
  COV_IRQ: cover property (@(posedge CLK) disable iff (!RST_B) $rose(IRQ));
  COV_SUSP: cover property (@(posedge CLK) disable iff (!RST_B)
    run_ff && suspended && tick_src);
  COV_COLLIDE: cover property (@(posedge CLK) disable iff (!RST_B)
    ctrl_wr && |mod_set);
endmodule
`default_nettype wire

// ==== verification/cat_cpu_model.sv ====
// processor-side model issuing register bus cycles
`timescale 1ns/10ps
`default_nettype none
module cat_cpu_model
  import cat_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register bus
  output var cat_sfr_s    sfr,
  input  wire logic [7:0] rdata
);
  initial sfr = '0;
  // firmware clears a flag only by writing it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    // released bus shows the inverse, not a stale copy
    sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the counter array timebase control
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import cat_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        t0 = 1'b0;
  logic        external_count_input = 1'b1;
  logic        ext = 1'b0;
  logic        lf = 1'b0;
  cat_sfr_s    sfr;
  cat_mod_s    mod = '0;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic [15:0] cnt;
  logic        tick;
  logic        irq;
  logic        hit;
  logic        hit_rd = 1'b0;
  int          errors = 0;
  int          n_compared = 0;
  int          nt = 0;
  int          k;
  int          b;
  int          w;

  always #10 clk = ~clk;
  always @(posedge clk) if (tick) nt <= nt + 1;
  // address decode seen at the edge that takes the read strobe
  always @(posedge clk) if (sfr.rd) hit_rd <= hit;

  cat_timebase cat_timebase_inst (.CLK(clk), .RST_B(rst_b), .SFR(sfr),
    .SFR_RDATA(rdata), .SFR_HIT(hit), .CPU_IDLE(cpu_idle), .T0_OVF(t0),
    .ECI_PIN(external_count_input), .EXT_OSC(ext), .LF_OSC(lf), .MOD(mod), .COUNT(cnt),
    .COUNT_TICK(tick), .IRQ(irq));
  cat_cpu_model cat_cpu_model_inst (.clk(clk), .sfr(sfr), .rdata(rdata));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
    cat_cpu_model_inst.rd(a, rv);
    `CHK(nm, e, rv)
    `CHK("sfr_hit", (a == CAT_CTRL_ADDR || a == CAT_MODE_ADDR), hit_rd)
  endtask

  task automatic stim(input int kind);
    case (kind)
      1: repeat (6) begin
        @(posedge clk);
        external_count_input <= 1'b0;
        repeat (4) @(posedge clk);
        external_count_input <= 1'b1;
        repeat (3) @(posedge clk);
      end
      2: repeat (k) begin
        @(posedge clk);
        t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
        repeat (2) @(posedge clk);
      end
      3: repeat (32) begin
        repeat (3) @(posedge clk);
        ext <= ~ext;
      end
      4: repeat (32) begin
        repeat (3) @(posedge clk);
        lf <= ~lf;
      end
      default: ;
    endcase
  endtask

  // fixed 120-cycle window holds whole periods of the divide-by-12 and divide-by-4 dividers
  task automatic win(input string nm, input logic [7:0] md, input int kind,
                     input int ex);
    logic [15:0] c0;
    int          n0;
    cat_cpu_model_inst.wr(CAT_MODE_ADDR, md);
    repeat (3) @(posedge clk);
    #1 c0 = cnt;
    n0 = nt;
    fork
      repeat (120) @(posedge clk);
      stim(kind);
    join
    #1 `CHK(nm, ex, nt - n0)
    `CHK("count_step", 16'(nt - n0), 16'(cnt - c0))
    $display("test %s done", nm);
  endtask

  task automatic pulse(input int bit_i, input bit pwm);
    logic [5:0] m;
    m = 6'(1 << bit_i);
    @(posedge clk);
    if (pwm)
      mod.pwm_edge <= m;
    else
      mod.capcmp <= m;
    @(posedge clk);
    mod.capcmp <= '0;
    mod.pwm_edge <= '0;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(44343));
    k = 1 + $urandom % 8;
    b = $urandom % 6;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chk_reg("ctrl_rst", CAT_CTRL_ADDR, CAT_CTRL_RST);
    chk_reg("mode_rst", CAT_MODE_ADDR, CAT_MODE_RST);
    chk_reg("unmapped", 8'hDA, 8'h00);
    cat_cpu_model_inst.wr(CAT_MODE_ADDR, 8'hFE);
    chk_reg("mode_rsvd", CAT_MODE_ADDR, 8'h8E);
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h40);
    win("div12", 8'h00, 0, 10);
    win("div4", 8'h02, 0, 30);
    win("t0", 8'h04, 2, k);
    win("eci", 8'h06, 1, 6);
    win("sys", 8'h08, 0, 120);
    win("ext", 8'h0A, 3, 2);
    win("lf", 8'h0C, 4, 2);
    win("none", 8'h0E, 0, 0);
    @(posedge clk);
    cpu_idle <= 1'b1;
    win("idle_susp", 8'h88, 0, 0);
    win("idle_run", 8'h08, 0, 120);
    @(posedge clk);
    cpu_idle <= 1'b0;
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h00);
    win("stopped", 8'h08, 0, 0);
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h40);
    cat_cpu_model_inst.wr(CAT_MODE_ADDR, 8'h09);
    #1 w = 0;
    while (cnt !== 16'hFFFF && w < 70000) begin
      @(posedge clk);
      #1 w++;
    end
    @(posedge clk);
    #1 `CHK("wrap", 16'h0000, cnt)
    @(posedge clk);
    #1 `CHK("irq_ovf", 1'b1, irq)
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h80);
    cat_cpu_model_inst.wr(CAT_MODE_ADDR, 8'h08);
    repeat (2) @(posedge clk);
    #1 `CHK("irq_mask", 1'b0, irq)
    chk_reg("cf_held", CAT_CTRL_ADDR, 8'h80);
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h00);
    chk_reg("cf_clr", CAT_CTRL_ADDR, 8'h00);
    $display("test overflow done");
    @(posedge clk);
    mod.int_en <= 6'(1 << b);
    pulse(b, 1'b0);
    repeat (2) @(posedge clk);
    #1 `CHK("irq_mod", 1'b1, irq)
    chk_reg("flag_set", CAT_CTRL_ADDR, 8'(1 << b));
    fork
      cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h00);
      pulse(b, 1'b0);
    join
    chk_reg("set_wins", CAT_CTRL_ADDR, 8'(1 << b));
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    #1 `CHK("irq_clr", 1'b0, irq)
    @(posedge clk);
    mod.pwm_mode <= '1;
    mod.match_en <= '1;
    pulse(b, 1'b1);
    chk_reg("pwm_set", CAT_CTRL_ADDR, 8'(1 << b));
    cat_cpu_model_inst.wr(CAT_CTRL_ADDR, 8'h00);
    mod.match_en <= '0;
    pulse(b, 1'b1);
    chk_reg("pwm_off", CAT_CTRL_ADDR, 8'h00);
    $display("test flags done");
    complete_run();
  end
endmodule
`default_nettype wire
